// ==== src/crr_pkg.sv ====
package crr_pkg;
    // register word offsets (printed offsets are not multiples of four: index, byte = 4*index)
    localparam logic [7:0] REG_CM_GAIN_IDX   = 8'h65;
    localparam logic [7:0] REG_CUR_LIM_IDX   = 8'h66;
    localparam logic [7:0] REG_MON_ADC_IDX   = 8'h67;
    localparam logic [7:0] REG_ANA_OFS_IDX   = 8'h68;
    localparam logic [7:0] REG_AUD_DAC_IDX   = 8'h69;
    localparam logic [7:0] REG_PEAK_CUR_IDX  = 8'h6B;
    localparam logic [7:0] REG_FEAT_EN_IDX   = 8'h6C;
    localparam logic [7:0] REG_STATUS_IDX    = 8'h70;
    localparam int         ADDR_W            = 10;
    localparam int         IDX_LSB           = 2;

    // read masks: reserved bits read zero
    localparam logic [7:0] MASK_CM_GAIN  = 8'h1F;
    localparam logic [7:0] MASK_CUR_LIM  = 8'h0F;
    localparam logic [7:0] MASK_MON_ADC  = 8'hFF;
    localparam logic [7:0] MASK_ANA_OFS  = 8'h0F;
    localparam logic [7:0] MASK_AUD_DAC  = 8'hFF;
    localparam logic [7:0] MASK_PEAK_CUR = 8'h0F;
    localparam logic [7:0] MASK_FEAT_EN  = 8'hE7;

    // reset values
    localparam logic [7:0] RST_CM_GAIN  = 8'h11;
    localparam logic [7:0] RST_CUR_LIM  = 8'h08;
    localparam logic [7:0] RST_ZERO     = 8'h00;

    // enhancement bit positions
    localparam int BIT_CAP_BOOST  = 7;
    localparam int BIT_TONE_BOOST = 6;
    localparam int BIT_SPEEDUP    = 5;
    localparam int BIT_VOLT_LOOP  = 2;
    localparam int BIT_SQUELCH    = 1;
    localparam int BIT_HYST       = 0;

    // current cap boost value in mA
    localparam logic [7:0] BOOST_CAP_MA = 8'h29;

    // tone timing: 8 kHz and 24 kHz tick periods derived from 20 MHz clock
    localparam int CLK_HZ        = 20000000;
    localparam int TONE_SLOW_HZ  = 8000;
    localparam int TONE_FAST_HZ  = 24000;
    localparam int SLOW_CYC      = CLK_HZ / TONE_SLOW_HZ;
    localparam int FAST_CYC      = CLK_HZ / TONE_FAST_HZ;
    localparam int TICK_W        = 12;
    // fine timer step 41.67 us in ns, cycles derived (rounded down)
    localparam int FINE_STEP_NS  = 41670;
    localparam int CLK_NS        = 50;
    localparam int FINE_STEP_CYC = FINE_STEP_NS / CLK_NS;

    // indirect register numbers for oscillator 1 selection and loop-detect hysteresis thresholds
    localparam logic [6:0] IND_TONE_ONE_FREQUENCY_COEFF_BASE  = 7'h00;
    localparam logic [6:0] IND_FSK_BASE   = 7'h45;
    localparam logic [6:0] IND_HYST_UPPER = 7'h0F;
    localparam logic [6:0] IND_HYST_LOWER = 7'h42;

    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // write-side slave states
    typedef enum logic [1:0] {
        CRR_W_IDLE = 2'b00,
        CRR_W_RESP = 2'b01
    } crr_wst_e;
endpackage : crr_pkg

// ==== src/crr_tone_clock.sv ====
`timescale 1ns/1ps
// tone generator 1 tick source: picks 8 kHz or 24 kHz period
module crr_tone_clock
    import crr_pkg::*;
(
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // control
    input  wire logic fast_sel,
    // tick out
    output logic      tick_ff
);
    typedef struct packed {
        logic [TICK_W-1:0] cnt;
        logic              tick;
    } crr_tc_s;

    crr_tc_s st_ff;   // registered state
    crr_tc_s nxt_st;  // next state

    // period compared live against the count; a switch applies to the span in progress
    logic [TICK_W-1:0] limit;
    assign limit = fast_sel ? TICK_W'(FAST_CYC - 1) : TICK_W'(SLOW_CYC - 1);

    // counter next state
    always_comb begin
        nxt_st      = st_ff;
        nxt_st.tick = 1'b0;
        if (st_ff.cnt >= limit) begin
            nxt_st.cnt  = '0;
            nxt_st.tick = 1'b1;
        end else begin
            nxt_st.cnt = st_ff.cnt + TICK_W'(1);
        end
    end

    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tick_ff = st_ff.tick;
endmodule : crr_tone_clock

// ==== src/crr_regs.sv ====
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module crr_regs
    import crr_pkg::*;
(
    // clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // axi write address
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // axi write data
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // axi write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // axi read address
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // axi read data
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // analog/dsp status inputs
    input  wire logic              caller_id_active_flag,
    input  wire logic              ring_burst_end,
    input  wire logic              linefeed_settled,
    input  wire logic [7:0]        loop_current_cap_setting,
    // trim outputs
    output logic [4:0]             cm_gain_trim,
    output logic [3:0]             current_cap_trim,
    output logic [3:0]             monitor_offset_trim_a,
    output logic [3:0]             monitor_offset_trim_b,
    output logic                   dac_positive_trim,
    output logic                   dac_negative_trim,
    output logic                   adc_positive_trim,
    output logic                   adc_negative_trim,
    output logic [7:0]             audio_dac_offset_trim,
    output logic [3:0]             peak_current_trim,
    // feature controls
    output logic [7:0]             loop_current_cap_ma,
    output logic                   tone_one_tick,
    output logic                   tone_one_fast,
    output logic [6:0]             tone_one_coeff_base,
    output logic                   fine_timer_step,
    output logic                   converter_multi_thresh,
    output logic                   converter_squelch_on,
    output logic                   loop_detect_by_voltage,
    output logic                   loop_detect_hyst_on,
    output logic [6:0]             hyst_upper_index,
    output logic [6:0]             hyst_lower_index
);
    // byte-wide register storage, indexed
    localparam int NREG = 7;

    typedef struct packed {
        logic [NREG-1:0][7:0] regs;
        crr_wst_e             wst;
        logic [ADDR_W-1:0]    awaddr;
        logic                 aw_got;
        logic [31:0]          wdata;
        logic                 wstrb0;
        logic                 w_got;
        logic [1:0]           bresp;
        logic                 rvalid;
        logic [31:0]          rdata;
        logic [1:0]           rresp;
        logic                 boost_active;
        logic [7:0]           cap_ma;
        logic                 fast;
        logic [6:0]           coeff_base;
        logic [TICK_W-1:0]    fine_cnt;
        logic                 fine_tick;
        logic                 mth;
        logic                 sq;
        logic                 vlc;
        logic                 hy;
        logic [6:0]           hy_up;
        logic [6:0]           hy_lo;
    } crr_st_s;

    crr_st_s st_ff;   // registered state
    crr_st_s nxt_st;  // next state
    logic    tick_ff; // tone one tick from divider

    // map a word index to a storage slot; slot NREG means unmapped
    function automatic logic [2:0] slot_of(input logic [ADDR_W-1:0] a);
        logic [7:0] idx;
        idx = a[ADDR_W-1:IDX_LSB];
        case (idx)
            REG_CM_GAIN_IDX:  slot_of = 3'd0;
            REG_CUR_LIM_IDX:  slot_of = 3'd1;
            REG_MON_ADC_IDX:  slot_of = 3'd2;
            REG_ANA_OFS_IDX:  slot_of = 3'd3;
            REG_AUD_DAC_IDX:  slot_of = 3'd4;
            REG_PEAK_CUR_IDX: slot_of = 3'd5;
            REG_FEAT_EN_IDX:  slot_of = 3'd6;
            default:          slot_of = 3'd7;
        endcase
    endfunction : slot_of

    // writable-bit mask per slot; reserved positions never store
    function automatic logic [7:0] mask_of(input logic [2:0] s);
        case (s)
            3'd0:    mask_of = MASK_CM_GAIN;
            3'd1:    mask_of = MASK_CUR_LIM;
            3'd2:    mask_of = MASK_MON_ADC;
            3'd3:    mask_of = MASK_ANA_OFS;
            3'd4:    mask_of = MASK_AUD_DAC;
            3'd5:    mask_of = MASK_PEAK_CUR;
            3'd6:    mask_of = MASK_FEAT_EN;
            default: mask_of = 8'h00;
        endcase
    endfunction : mask_of

    logic [7:0] feat;
    assign feat = st_ff.regs[6];

    // all register and bus next-state logic
    always_comb begin
        logic [2:0] wslot;
        logic [2:0] rslot;
        logic [7:0] ridx;
        wslot  = slot_of(st_ff.awaddr);
        rslot  = slot_of(s_axi_araddr);
        ridx   = s_axi_araddr[ADDR_W-1:IDX_LSB];
        nxt_st = st_ff;

        // write channel: address and data taken in either order
        case (st_ff.wst)
            CRR_W_IDLE: begin
                if (s_axi_awvalid && !st_ff.aw_got) begin
                    nxt_st.awaddr = s_axi_awaddr;
                    nxt_st.aw_got = 1'b1;
                end
                if (s_axi_wvalid && !st_ff.w_got) begin
                    nxt_st.wdata  = s_axi_wdata;
                    nxt_st.wstrb0 = s_axi_wstrb[0];
                    nxt_st.w_got  = 1'b1;
                end
                if (st_ff.aw_got && st_ff.w_got) begin
                    if (wslot == 3'd7) begin
                        nxt_st.bresp = RESP_SLVERR;
                    end else begin
                        nxt_st.bresp = RESP_OKAY;
                        // only lane 0 carries register data
                        if (st_ff.wstrb0) begin
                            nxt_st.regs[wslot] = st_ff.wdata[7:0] & mask_of(wslot);
                        end
                    end
                    nxt_st.aw_got = 1'b0;
                    nxt_st.w_got  = 1'b0;
                    nxt_st.wst    = CRR_W_RESP;
                end
            end
            CRR_W_RESP: begin
                if (s_axi_bready) begin
                    nxt_st.wst = CRR_W_IDLE;
                end
            end
            default: begin
                nxt_st.wst = CRR_W_IDLE;
            end
        endcase

        // read channel: one cycle to answer, held until rready
        if (st_ff.rvalid) begin
            if (s_axi_rready) begin
                nxt_st.rvalid = 1'b0;
            end
        end else if (s_axi_arvalid) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp  = RESP_OKAY;
            if (rslot != 3'd7) begin
                nxt_st.rdata = {24'h000000, st_ff.regs[rslot] & mask_of(rslot)};
            end else if (ridx == REG_STATUS_IDX) begin
                // live feature state for software
                nxt_st.rdata = {24'h000000, st_ff.cap_ma};
                nxt_st.rdata[8] = st_ff.boost_active;
                nxt_st.rdata[9] = st_ff.fast;
            end else begin
                nxt_st.rdata = 32'h00000000;
                nxt_st.rresp = RESP_SLVERR;
            end
        end

        // boost window: opens at ring burst end, closes once settled
        if (!feat[BIT_CAP_BOOST] || linefeed_settled) begin
            nxt_st.boost_active = 1'b0;
        end
        if (feat[BIT_CAP_BOOST] && ring_burst_end) begin
            nxt_st.boost_active = 1'b1;
        end
        nxt_st.cap_ma = nxt_st.boost_active ? BOOST_CAP_MA : loop_current_cap_setting;

        // fsk enhancement only while caller-id is active
        nxt_st.fast       = feat[BIT_TONE_BOOST] && caller_id_active_flag;
        nxt_st.coeff_base = nxt_st.fast ? IND_FSK_BASE : IND_TONE_ONE_FREQUENCY_COEFF_BASE;

        // fine timer step tick, free running only in fast mode
        nxt_st.fine_tick = 1'b0;
        if (!st_ff.fast) begin
            nxt_st.fine_cnt = '0;
        end else if (st_ff.fine_cnt >= TICK_W'(FINE_STEP_CYC - 1)) begin
            nxt_st.fine_cnt  = '0;
            nxt_st.fine_tick = 1'b1;
        end else begin
            nxt_st.fine_cnt = st_ff.fine_cnt + TICK_W'(1);
        end

        // converter and loop-detect controls
        nxt_st.mth   = feat[BIT_SPEEDUP];
        nxt_st.vlc   = feat[BIT_VOLT_LOOP];
        nxt_st.sq    = feat[BIT_SQUELCH];
        nxt_st.hy    = feat[BIT_HYST];
        // with hysteresis off both thresholds come from the upper one
        nxt_st.hy_up = IND_HYST_UPPER;
        nxt_st.hy_lo = feat[BIT_HYST] ? IND_HYST_LOWER : IND_HYST_UPPER;
    end

    // state register, synchronous reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff         <= '0;
            st_ff.regs[0] <= RST_CM_GAIN;
            st_ff.regs[1] <= RST_CUR_LIM;
            st_ff.regs[3] <= RST_ZERO;
            st_ff.wst     <= CRR_W_IDLE;
            st_ff.hy_up   <= IND_HYST_UPPER;
            st_ff.hy_lo   <= IND_HYST_UPPER;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // tone one clock divider
    crr_tone_clock u_tone (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .fast_sel (st_ff.fast),
        .tick_ff  (tick_ff)
    );

    // bus outputs
    assign s_axi_awready = (st_ff.wst == CRR_W_IDLE) && !st_ff.aw_got;
    assign s_axi_wready  = (st_ff.wst == CRR_W_IDLE) && !st_ff.w_got;
    assign s_axi_bvalid  = (st_ff.wst == CRR_W_RESP);
    assign s_axi_bresp   = st_ff.bresp;
    assign s_axi_arready = !st_ff.rvalid;
    assign s_axi_rvalid  = st_ff.rvalid;
    assign s_axi_rdata   = st_ff.rdata;
    assign s_axi_rresp   = st_ff.rresp;

    // trims straight from storage
    assign cm_gain_trim          = st_ff.regs[0][4:0];
    assign current_cap_trim      = st_ff.regs[1][3:0];
    assign monitor_offset_trim_a = st_ff.regs[2][7:4];
    assign monitor_offset_trim_b = st_ff.regs[2][3:0];
    assign dac_positive_trim     = st_ff.regs[3][3];
    assign dac_negative_trim     = st_ff.regs[3][2];
    assign adc_positive_trim     = st_ff.regs[3][1];
    assign adc_negative_trim     = st_ff.regs[3][0];
    assign audio_dac_offset_trim = st_ff.regs[4];
    assign peak_current_trim     = st_ff.regs[5][3:0];

    // feature controls
    assign loop_current_cap_ma    = st_ff.cap_ma;
    assign tone_one_tick          = tick_ff;
    assign tone_one_fast          = st_ff.fast;
    assign tone_one_coeff_base    = st_ff.coeff_base;
    assign fine_timer_step        = st_ff.fine_tick;
    assign converter_multi_thresh = st_ff.mth;
    assign converter_squelch_on   = st_ff.sq;
    assign loop_detect_by_voltage = st_ff.vlc;
    assign loop_detect_hyst_on    = st_ff.hy;
    assign hyst_upper_index       = st_ff.hy_up;
    assign hyst_lower_index       = st_ff.hy_lo;
endmodule : crr_regs

// ==== dv/crr_regs_monitor.sv ====
`timescale 1ns/1ps
// passive checker on the register block's ports
module crr_regs_monitor
    import crr_pkg::*;
(
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // bus answers
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_bvalid,
    // line-side inputs
    input wire logic [7:0]  loop_current_cap_setting,
    input wire logic        caller_id_active_flag,
    // trims and feature controls
    input wire logic [4:0]  cm_gain_trim,
    input wire logic [3:0]  current_cap_trim,
    input wire logic [7:0]  loop_current_cap_ma,
    input wire logic        tone_one_tick,
    input wire logic        tone_one_fast,
    input wire logic [6:0]  tone_one_coeff_base,
    input wire logic        fine_timer_step,
    input wire logic        converter_multi_thresh,
    input wire logic        converter_squelch_on,
    input wire logic        loop_detect_by_voltage,
    input wire logic        loop_detect_hyst_on,
    input wire logic [6:0]  hyst_upper_index,
    input wire logic [6:0]  hyst_lower_index
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // cycles since the last tone tick; spans that saw a rate change are skipped
    logic [15:0] gap_ff;
    logic        seen_ff;  // first tick after reset has no reference
    logic        slow_ff;  // span saw the slow rate
    logic        fast_ff;  // span saw the fast rate
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gap_ff  <= 16'h0000;
            seen_ff <= 1'b0;
            slow_ff <= 1'b0;
            fast_ff <= 1'b0;
        end else if (tone_one_tick) begin
            gap_ff  <= 16'h0001;
            seen_ff <= 1'b1;
            slow_ff <= !tone_one_fast;
            fast_ff <= tone_one_fast;
        end else begin
            gap_ff  <= gap_ff + 16'h0001;
            slow_ff <= slow_ff | !tone_one_fast;
            fast_ff <= fast_ff | tone_one_fast;
        end
    end

    sequence s_slow_span;
        tone_one_tick && seen_ff && !fast_ff;
    endsequence
    sequence s_fast_span;
        tone_one_tick && seen_ff && !slow_ff;
    endsequence

    property p_rsvd_zero;
        s_axi_rvalid |-> s_axi_rdata[31:10] == 22'h000000;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("upper read data not zero");
    property p_rst_vals;
        disable iff (1'b0) $rose(aresetn) |-> cm_gain_trim == 5'h11 && current_cap_trim == 4'h8;
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("trim reset value wrong");
    property p_boost;
        $past(aresetn) && loop_current_cap_ma != $past(loop_current_cap_setting)
            |-> loop_current_cap_ma == 8'h29;
    endproperty
    a_boost: assert property (p_boost) else $error("cap differs from setting but not 41");
    property p_fast_off;
        !caller_id_active_flag |=> !tone_one_fast;
    endproperty
    a_fast_off: assert property (p_fast_off) else $error("fast tone without caller id");
    property p_slow_tick;
        s_slow_span |-> gap_ff == 16'h09C4;
    endproperty
    a_slow_tick: assert property (p_slow_tick) else $error("slow tick spacing wrong");
    property p_fast_tick;
        s_fast_span |-> gap_ff == 16'h0341;
    endproperty
    a_fast_tick: assert property (p_fast_tick) else $error("fast tick spacing wrong");
    property p_coeff;
        $stable(tone_one_fast) |-> tone_one_coeff_base == (tone_one_fast ? 7'h45 : 7'h00);
    endproperty
    a_coeff: assert property (p_coeff) else $error("oscillator base wrong");
    property p_fine;
        fine_timer_step |-> tone_one_fast || $past(tone_one_fast);
    endproperty
    a_fine: assert property (p_fine) else $error("fine step outside fast mode");
    property p_feat;
        $changed({converter_multi_thresh, converter_squelch_on, loop_detect_by_voltage})
            |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2);
    endproperty
    a_feat: assert property (p_feat) else $error("feature changed without write");
    property p_hyst;
        $stable(loop_detect_hyst_on) |-> hyst_upper_index == 7'h0F
            && hyst_lower_index == (loop_detect_hyst_on ? 7'h42 : 7'h0F);
    endproperty
    a_hyst: assert property (p_hyst) else $error("hysteresis index wrong");

    // cycles since the last fine step; a span that left fast mode is not judged
    logic [15:0] fgap_ff;
    logic        fseen_ff; // a fine step seen inside the current fast stretch
    always_ff @(posedge aclk) begin
        if (!aresetn || !tone_one_fast) begin
            fgap_ff  <= 16'h0000;
            fseen_ff <= 1'b0;
        end else if (fine_timer_step) begin
            fgap_ff  <= 16'h0001;
            fseen_ff <= 1'b1;
        end else begin
            fgap_ff  <= fgap_ff + 16'h0001;
        end
    end

    property p_fine_gap;
        fine_timer_step && fseen_ff |-> fgap_ff == 16'h0341;
    endproperty
    a_fine_gap: assert property (p_fine_gap) else $error("fine step spacing wrong");
endmodule : crr_regs_monitor

// ==== dv/tb.sv ====
`timescale 1ns/1ps
// register bank bench: bus tasks plus directed sequences
module tb;
    import crr_pkg::*;
    // bus master side
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic              s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [31:0]       s_axi_wdata, s_axi_rdata;
    logic [3:0]        s_axi_wstrb;
    logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    // line side and clock
    logic              aclk, aresetn, caller_id_active_flag, ring_burst_end, linefeed_settled;
    logic [7:0]        loop_current_cap_setting, audio_dac_offset_trim, loop_current_cap_ma;
    // block outputs
    logic [4:0]        cm_gain_trim;
    logic [3:0]        current_cap_trim, monitor_offset_trim_a, monitor_offset_trim_b;
    logic [3:0]        peak_current_trim;
    logic              dac_positive_trim, dac_negative_trim, adc_positive_trim, adc_negative_trim;
    logic              tone_one_tick, tone_one_fast, fine_timer_step, converter_multi_thresh;
    logic              converter_squelch_on, loop_detect_by_voltage, loop_detect_hyst_on;
    logic [6:0]        tone_one_coeff_base, hyst_upper_index, hyst_lower_index;
    int                bad_count, num_checks;
    // register table: index, reset value, readable bits
    logic [7:0] idx_tab [7] = '{REG_CM_GAIN_IDX, REG_CUR_LIM_IDX, REG_MON_ADC_IDX,
        REG_ANA_OFS_IDX, REG_AUD_DAC_IDX, REG_PEAK_CUR_IDX, REG_FEAT_EN_IDX};
    logic [7:0] rst_tab [7] = '{8'h11, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] msk_tab [7] = '{8'h1F, 8'h0F, 8'hFF, 8'h0F, 8'hFF, 8'h0F, 8'hE7};
    logic [7:0] pats [2] = '{8'hA5, 8'h5A};
    logic [7:0] feat_tab [4] = '{8'h20, 8'h04, 8'h02, 8'h01};

    crr_regs uut (.*);

    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    // one comparison, counted
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // address and data offered together, each released once taken
    task automatic axi_write(input logic [7:0] idx, input logic [7:0] data, input logic [1:0] er);
        logic aw_p, w_p, ta, tw;
        aw_p = 1'b1;
        w_p = 1'b1;
        @(posedge aclk);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {24'h000000, data};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (aw_p || w_p) begin
            @(negedge aclk);
            ta = aw_p && s_axi_awready === 1'b1;
            tw = w_p && s_axi_wready === 1'b1;
            @(posedge aclk);
            if (ta) begin
                s_axi_awvalid <= 1'b0;
                aw_p = 1'b0;
            end
            if (tw) begin
                s_axi_wvalid <= 1'b0;
                w_p = 1'b0;
            end
        end
        do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
        check("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask : axi_write

    // read with expected byte and response
    task automatic axi_read(input logic [7:0] idx, input logic [7:0] exp, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(negedge aclk); while (s_axi_arready !== 1'b1);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
        check("rdata", s_axi_rdata, {24'h000000, exp});
        check("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask : axi_read

    // short pulse on the ring-end input
    task automatic pulse_ring;
        @(posedge aclk);
        ring_burst_end <= 1'b1;
        @(posedge aclk);
        ring_burst_end <= 1'b0;
        repeat (4) @(negedge aclk);
    endtask : pulse_ring

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop

    // watchdog: the whole run needs about 8100 cycles
    initial begin
        #(50 * 30000);
        bad_count++;
        report_and_stop();
    end

    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {caller_id_active_flag, ring_burst_end, linefeed_settled} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'h1;
        loop_current_cap_setting = 8'h14;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 7; i++) axi_read(idx_tab[i], rst_tab[i], RESP_OKAY);
        $display("test reset_values done");
        foreach (pats[p]) begin
            for (int i = 0; i < 7; i++) begin
                axi_write(idx_tab[i], pats[p], RESP_OKAY);
                axi_read(idx_tab[i], pats[p] & msk_tab[i], RESP_OKAY);
            end
        end
        check("cm_gain", {27'h0, cm_gain_trim}, 32'h1A);
        check("cur_cap", {28'h0, current_cap_trim}, 32'hA);
        check("mon", {24'h0, monitor_offset_trim_a, monitor_offset_trim_b}, 32'h5A);
        check("ana", {28'h0, dac_positive_trim, dac_negative_trim, adc_positive_trim,
            adc_negative_trim}, 32'hA);
        check("aud", {24'h0, audio_dac_offset_trim}, 32'h5A);
        check("peak", {28'h0, peak_current_trim}, 32'hA);
        // lane 0 strobe low: the word is answered but nothing is stored
        s_axi_wstrb <= 4'h0;
        axi_write(REG_CM_GAIN_IDX, 8'h03, RESP_OKAY);
        s_axi_wstrb <= 4'h1;
        axi_read(REG_CM_GAIN_IDX, 8'h1A, RESP_OKAY);
        axi_write(8'h6A, 8'hFF, RESP_SLVERR);
        axi_read(8'h6A, 8'h00, RESP_SLVERR);
        $display("test field_access done");
        for (int i = 0; i < 4; i++) begin
            axi_write(REG_FEAT_EN_IDX, feat_tab[i], RESP_OKAY);
            repeat (4) @(negedge aclk);
            check("feat", {28'h0, converter_multi_thresh, loop_detect_by_voltage,
                converter_squelch_on, loop_detect_hyst_on}, 32'h8 >> i);
        end
        check("hyst", {18'h0, hyst_upper_index, hyst_lower_index}, 32'h07C2);
        axi_write(REG_FEAT_EN_IDX, 8'h00, RESP_OKAY);
        repeat (4) @(negedge aclk);
        check("hyst_off", {18'h0, hyst_upper_index, hyst_lower_index}, 32'h078F);
        $display("test feature_bits done");
        repeat (5200) @(posedge aclk);
        caller_id_active_flag <= 1'b1;
        axi_write(REG_FEAT_EN_IDX, 8'h40, RESP_OKAY);
        repeat (4) @(negedge aclk);
        check("fast", {24'h0, tone_one_fast, tone_one_coeff_base}, 32'hC5);
        repeat (2600) @(posedge aclk);
        caller_id_active_flag <= 1'b0;
        repeat (4) @(negedge aclk);
        check("slow", {24'h0, tone_one_fast, tone_one_coeff_base}, 32'h00);
        @(posedge aclk);
        caller_id_active_flag <= 1'b1;
        axi_write(REG_FEAT_EN_IDX, 8'h00, RESP_OKAY);
        repeat (4) @(negedge aclk);
        check("no_en", {31'h0, tone_one_fast}, 32'h0);
        $display("test tone_rate done");
        axi_write(REG_FEAT_EN_IDX, 8'h80, RESP_OKAY);
        pulse_ring();
        check("boost", {24'h0, loop_current_cap_ma}, 32'h29);
        @(posedge aclk);
        linefeed_settled <= 1'b1;
        repeat (4) @(negedge aclk);
        check("settled", {24'h0, loop_current_cap_ma}, 32'h14);
        // status word: cap in the low byte, boost and fast flags clear
        axi_read(REG_STATUS_IDX, 8'h14, RESP_OKAY);
        axi_write(REG_FEAT_EN_IDX, 8'h00, RESP_OKAY);
        linefeed_settled <= 1'b0;
        loop_current_cap_setting <= 8'h1E;
        pulse_ring();
        check("no_boost", {24'h0, loop_current_cap_ma}, 32'h1E);
        axi_read(REG_STATUS_IDX, 8'h1E, RESP_OKAY);
        $display("test current_boost done");
        report_and_stop();
    end
endmodule : tb

bind crr_regs crr_regs_monitor mon (.*);
